// file: logic/ebr_core.sv
// Configurable 10-kbit synchronous block memory with two ports and preload.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R01 - The array holds 10240 bits and every read and write is synchronous.
// R02 - The block runs as single-port RAM, simple dual-port, true dual-port or ROM.
// R03 - A preload port writes initial contents before normal operation.
// R04 - User logic must not trust locations never preloaded or written.
// R05 - Read and write widths are selected independently per port.
// R06 - Each port has an address enable and a read output register reset.
// R07 - Simple dual-port writes update only the bytes whose enables are set.
// R08 - True dual-port shapes are 1024x8, 2048x4, 4096x2, 8192x1, 1024x10, 2048x5.
// R09 - Simple dual-port adds the 512x16 and 512x20 shapes.
// R10 - Each true dual-port port has its own data, address and control set.
// R11 - A port with clock enable low neither writes nor changes its read data; here output reset still clears it.
// R12 - With address enable low a port reuses its last latched address.
module ebr_core import ebr_pkg::*; (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Configuration
   input wire ebr_mode_t mode_i,
   input wire ebr_width_t width_a_i,
   input wire ebr_width_t width_b_i,
   input wire ebr_preload_t preload_i,
   // User ports
   input wire ebr_port_req_t port_a_i,
   input wire ebr_port_req_t port_b_i,
   output logic [DATA_W-1:0] rdata_a_o,
   output logic [DATA_W-1:0] rdata_b_o
);

   ////////////////////////////////////////////////////////////////////////
   // Storage: no reset, contents undefined until preloaded or written.
   // One flat bit array lets each port pick its own shape over the same
   // cells; a word of w bits at address a starts at bit a*w.
   logic mem [0:MEM_BITS-1]; // [R01]

   // Request and shape seen by each port
   ebr_port_req_t req [NPORT];
   ebr_width_t wsel [NPORT];
   // Latched address and registered read data
   logic [ADDR_W-1:0] addr_reg [NPORT];
   logic [ADDR_W-1:0] addr_next [NPORT];
   logic [ADDR_W-1:0] eff_addr [NPORT];
   logic [DATA_W-1:0] rdata_reg [NPORT];
   logic [DATA_W-1:0] rdata_next [NPORT];
   // Decoded word position, write mask and read word
   logic [DATA_W-1:0] rd_word [NPORT];
   logic [DATA_W-1:0] wmask [NPORT];
   logic [BIT_ADDR_W-1:0] base [NPORT];
   logic [CNT_W-1:0] wbits [NPORT];
   logic [BE_W-1:0] be_eff [NPORT];
   // Role of each port in the current mode
   logic rd_ok [NPORT];
   logic wr_ok [NPORT];

   assign req[0] = port_a_i;
   assign req[1] = port_b_i;
   // 8192x1 up to 1024x10 serve every mode; 512x16 and 512x20 take both
   // halves of the array, so they exist in simple dual-port only and
   // fall back to the 8- or 10-bit shape elsewhere
   assign wsel[0] = legal_width(mode_i, width_a_i); // [R05] [R08] [R09]
   assign wsel[1] = legal_width(mode_i, width_b_i); // [R05] [R08] [R09]

   ////////////////////////////////////////////////////////////////////////
   // Port roles per mode: port A is the write side and port B the read
   // side in simple dual-port; single-port leaves port B idle
   function automatic logic role_reads(input ebr_mode_t m, input int p);
      unique case (m)
         MODE_SP: begin
            role_reads = (p == 0);
         end
         MODE_SDP: begin
            role_reads = (p != 0);
         end
         MODE_TDP: begin
            role_reads = 1'h1;
         end
         MODE_ROM: begin
            role_reads = 1'h1;
         end
         // A mode code that is not one-hot leaves the port idle
         default: begin
            role_reads = 1'h0;
         end
      endcase
   endfunction

   // Only preload fills a ROM; user writes there are dropped silently
   function automatic logic role_writes(input ebr_mode_t m, input int p);
      unique case (m)
         MODE_SP: begin
            role_writes = (p == 0);
         end
         MODE_SDP: begin
            role_writes = (p == 0);
         end
         MODE_TDP: begin
            role_writes = 1'h1;
         end
         MODE_ROM: begin
            role_writes = 1'h0;
         end
         // Never write on an illegal mode code
         default: begin
            role_writes = 1'h0;
         end
      endcase
   endfunction

   // First array bit of a word: masked address times the shape width.
   // The product of every legal shape stays below the array size.
   function automatic logic [BIT_ADDR_W-1:0] word_base(
      input logic [ADDR_W-1:0] a, input ebr_width_t w);
      logic [BIT_ADDR_W-1:0] wide_addr;
      logic [BIT_ADDR_W-1:0] wide_bits;
      wide_addr = BIT_ADDR_W'(a & addr_mask(w));
      wide_bits = BIT_ADDR_W'(width_bits(w));
      word_base = BIT_ADDR_W'(wide_addr * wide_bits);
   endfunction

   // True when bit j of the word at base lies inside the array; guards
   // the reads and writes alike so no index runs past the last cell
   function automatic logic in_array(input logic [BIT_ADDR_W-1:0] b,
                                     input int j);
      in_array = (int'(b) + j) < MEM_BITS;
   endfunction

   // Byte enable that covers bit j: wide words split into two halves,
   // narrower words use the low enable only
   function automatic logic lane_enable(input logic [BE_W-1:0] be,
                                        input logic [CNT_W-1:0] w,
                                        input int j);
      if (w >= WIDE_MIN && j >= int'(w >> 1)) begin
         lane_enable = be[1];
      end else begin
         lane_enable = be[0];
      end
   endfunction

   // Preload words are always 10 bits wide, whatever shape the ports use
   function automatic int pre_bit(input logic [PRE_ADDR_W-1:0] a,
                                  input int j);
      pre_bit = int'(a) * PRE_DATA_W + j;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Per-port address, write mask and read register
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      // Next address, read word and write mask of one port
      always_comb begin
         rd_ok[p] = role_reads(mode_i, p); // [R02]
         wr_ok[p] = role_writes(mode_i, p); // [R02] [R10]
         // An access at this edge uses the new address at once; the latch
         // only matters while address enable is low
         eff_addr[p] = req[p].addr_en ? req[p].addr : addr_reg[p]; // [R12]
         addr_next[p] = addr_reg[p];
         if (req[p].ce && req[p].addr_en) begin
            addr_next[p] = req[p].addr; // [R06] [R12]
         end
         wbits[p] = width_bits(wsel[p]);
         base[p] = word_base(eff_addr[p], wsel[p]);
         be_eff[p] = (mode_i == MODE_SDP) ? req[p].be : BE_ALL; // [R07]
         for (int j = 0; j < DATA_W; j++) begin
            wmask[p][j] = lane_enable(be_eff[p], wbits[p], j); // [R07]
            wmask[p][j] = wmask[p][j] && req[p].ce && req[p].we && wr_ok[p]
                          && (j < int'(wbits[p])); // [R11]
            rd_word[p][j] = 1'h0;
            if (j < int'(wbits[p]) && in_array(base[p], j)) begin
               rd_word[p][j] = mem[int'(base[p]) + j];
            end
         end
         // Output reset wins over a read and ignores clock enable
         rdata_next[p] = rdata_reg[p];
         if (req[p].out_rst) begin
            rdata_next[p] = RDATA_RST; // [R06]
         end else if (req[p].ce && rd_ok[p]) begin
            // Read before write: same-edge write shows on the next read
            rdata_next[p] = rd_word[p]; // [R01] [R11]
         end
      end

      // Reset clears only the registers; the array keeps its contents
      always_ff @(posedge clk_sys_i) begin
         if (!rst_n_i) begin
            addr_reg[p] <= ADDR_RST;
            rdata_reg[p] <= RDATA_RST;
         end else begin
            addr_reg[p] <= addr_next[p];
            rdata_reg[p] <= rdata_next[p];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Array writes; later assignments win: B, then A, then preload.
   // A bit hit by both ports at one edge keeps port A's value and a
   // preload at the same edge overrides both; user logic that needs a
   // defined result must not aim both ports at one bit in one cycle
   always_ff @(posedge clk_sys_i) begin
      for (int q = NPORT - 1; q >= 0; q--) begin
         for (int j = 0; j < DATA_W; j++) begin
            if (wmask[q][j] && in_array(base[q], j)) begin
               mem[int'(base[q]) + j] <= req[q].wdata[j]; // [R01] [R07]
            end
         end
      end
      if (preload_i.we) begin
         for (int j = 0; j < PRE_DATA_W; j++) begin
            mem[pre_bit(preload_i.addr, j)] <= preload_i.data[j]; // [R03]
         end
      end
   end

   assign rdata_a_o = rdata_reg[0];
   assign rdata_b_o = rdata_reg[1];

endmodule
`default_nettype wire

// file: logic/ebr_pkg.sv
// Shared constants, modes, shapes and port carriers of the block memory.
`default_nettype none
package ebr_pkg;

   localparam int MEM_BITS = 10240;
   localparam int NPORT = 2;
   localparam int ADDR_W = 13;
   localparam int BIT_ADDR_W = 14;
   localparam int DATA_W = 20;
   localparam int CNT_W = 5;
   localparam int BE_W = 2;
   localparam int PRE_ADDR_W = 10;
   localparam int PRE_DATA_W = 10;
   localparam logic [CNT_W-1:0] WIDE_MIN = 5'h10;
   localparam logic [DATA_W-1:0] RDATA_RST = 20'h00000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
   localparam logic [BE_W-1:0] BE_ALL = 2'h3;

   typedef enum logic [3:0] {
      MODE_SP  = 4'h1,
      MODE_SDP = 4'h2,
      MODE_TDP = 4'h4,
      MODE_ROM = 4'h8
   } ebr_mode_t;

   typedef enum logic [7:0] {
      W1  = 8'h01,
      W2  = 8'h02,
      W4  = 8'h04,
      W5  = 8'h08,
      W8  = 8'h10,
      W10 = 8'h20,
      W16 = 8'h40,
      W20 = 8'h80
   } ebr_width_t;

   typedef struct packed {
      logic ce;
      logic addr_en;
      logic we;
      logic out_rst;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [BE_W-1:0] be;
   } ebr_port_req_t;

   typedef struct packed {
      logic we;
      logic [PRE_ADDR_W-1:0] addr;
      logic [PRE_DATA_W-1:0] data;
   } ebr_preload_t;

   // Bits per word of a shape
   function automatic logic [CNT_W-1:0] width_bits(input ebr_width_t w);
      unique case (w)
         W1: width_bits = 5'h01;
         W2: width_bits = 5'h02;
         W4: width_bits = 5'h04;
         W5: width_bits = 5'h05;
         W8: width_bits = 5'h08;
         W10: width_bits = 5'h0A;
         W16: width_bits = 5'h10;
         W20: width_bits = 5'h14;
         default: width_bits = 5'h08;
      endcase
   endfunction

   // Legal address bits for the depth of a shape
   function automatic logic [ADDR_W-1:0] addr_mask(input ebr_width_t w);
      unique case (w)
         W1: addr_mask = 13'h1FFF;
         W2: addr_mask = 13'h0FFF;
         W4, W5: addr_mask = 13'h07FF;
         W8, W10: addr_mask = 13'h03FF;
         W16, W20: addr_mask = 13'h01FF;
         default: addr_mask = 13'h03FF;
      endcase
   endfunction

   // Wide shapes exist only in simple dual-port operation
   function automatic ebr_width_t legal_width(input ebr_mode_t m,
                                              input ebr_width_t w);
      if (m != MODE_SDP && w == W16) begin
         legal_width = W8;
      end else if (m != MODE_SDP && w == W20) begin
         legal_width = W10;
      end else begin
         legal_width = w;
      end
   endfunction

endpackage
`default_nettype wire

// file: dv/ebr_monitor.sv
// Port-level checks on the read registers of the block memory.
`timescale 1ns/1ps
`default_nettype none
module ebr_monitor import ebr_pkg::*; (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Ports watched
   input wire ebr_mode_t mode_i,
   input wire ebr_port_req_t port_a_i,
   input wire ebr_port_req_t port_b_i,
   input wire logic [DATA_W-1:0] rdata_a_o,
   input wire logic [DATA_W-1:0] rdata_b_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   sequence quiet_a;
      !port_a_i.ce && !port_a_i.out_rst;
   endsequence
   sequence quiet_b;
      !port_b_i.ce && !port_b_i.out_rst;
   endsequence
   reset_zero_a: assert property (disable iff (1'h0)
      !rst_n_i |=> rdata_a_o == '0 && rdata_b_o == '0) else $error("reset");
   release_zero_a: assert property ($rose(rst_n_i) |->
      rdata_a_o == '0 && rdata_b_o == '0) else $error("release");
   pa_clear_a: assert property (port_a_i.out_rst |=>
      rdata_a_o == '0) else $error("clear a");
   pb_clear_a: assert property (port_b_i.out_rst |=>
      rdata_b_o == '0) else $error("clear b");
   pa_hold_a: assert property (quiet_a |=> $stable(rdata_a_o))
      else $error("hold a");
   pb_hold_a: assert property (quiet_b |=> $stable(rdata_b_o))
      else $error("hold b");
   clear_stays_a: assert property (port_a_i.out_rst ##1 quiet_a |=>
      rdata_a_o == '0) else $error("clear lost");
   sp_idle_a: assert property (mode_i == MODE_SP &&
      !port_b_i.out_rst |=> $stable(rdata_b_o)) else $error("idle b");
endmodule
`default_nettype wire

// file: dv/ebr_user.sv
// Behavioural user logic that presents requests on both ports.
`timescale 1ns/1ps
`default_nettype none
module ebr_user import ebr_pkg::*; (
   input wire logic clk_sys_i,
   output var ebr_port_req_t port_a_o,
   output var ebr_port_req_t port_b_o
);
   initial begin
      port_a_o = '0;
      port_b_o = '0;
   end
   // Each port has its own full request set, changed off the edge
   task automatic drive(input ebr_port_req_t a, input ebr_port_req_t b);
      @(negedge clk_sys_i);
      port_a_o = a;
      port_b_o = b;
   endtask
endmodule
`default_nettype wire

// file: dv/test_ebr_core.sv
// Self-checking test of the block memory.
`timescale 1ns/1ps
`default_nettype none
module test_ebr_core import ebr_pkg::*;;
   // Flags are {write, address enable, clock enable, output reset}
   localparam logic [3:0] WR = 4'hE, RD = 4'h6, RDH = 4'h2, CLR = 4'h7;
   localparam logic [3:0] NOCE = 4'hC, IDLE = 4'h0;
   logic clk_sys_i = 1'h0;
   logic rst_n_i = 1'h0;
   ebr_mode_t mode_i = MODE_TDP;
   ebr_width_t width_a_i = W8;
   ebr_width_t width_b_i = W8;
   ebr_preload_t preload_i = '0;
   ebr_port_req_t port_a_i, port_b_i;
   logic [DATA_W-1:0] rdata_a_o, rdata_b_o, m [4], q [$];
   int bad_count = 0;
   int comparisons = 0;
   logic ra, rb;
   always #50 clk_sys_i = ~clk_sys_i;
   ebr_core i_ebr_core (.clk_sys_i, .rst_n_i, .mode_i, .width_a_i,
      .width_b_i, .preload_i, .port_a_i, .port_b_i, .rdata_a_o, .rdata_b_o);
   ebr_user u_user (.clk_sys_i, .port_a_o(port_a_i), .port_b_o(port_b_i));
   task automatic go(input logic p, input logic [3:0] f,
      input logic [12:0] a, input logic [19:0] d, input logic [1:0] be);
      ebr_port_req_t r, z;
      z = '0;
      r = '{f[1], f[2], f[3], f[0], a, d, be};
      u_user.drive(p ? z : r, p ? r : z);
   endtask
   task automatic fin(input int n);
      go(1'h0, IDLE, 13'h0000, 20'h00000, 2'h0);
      $display("test %0d done", n);
   endtask
   task automatic cmp(input logic [19:0] v);
      logic [19:0] e;
      e = q.size() != 0 ? q.pop_front() : 'x;
      comparisons++;
      if (e !== v) begin
         bad_count++;
         $display("Error at %0t: expected %h, got %h", $time, e, v);
      end
   endtask
   task automatic end_of_test;
      if (q.size() != 0) bad_count++;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // A read result lands one edge after the request
   always @(posedge clk_sys_i) begin
      ra = rst_n_i && (port_a_i.out_rst || port_a_i.ce && !port_a_i.we);
      rb = rst_n_i && (port_b_i.out_rst || port_b_i.ce && !port_b_i.we);
      #1;
      if (ra) cmp(rdata_a_o);
      if (rb) cmp(rdata_b_o);
   end
   initial begin
      repeat (2000) @(posedge clk_sys_i);
      bad_count++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'hAC68));
      repeat (8) @(negedge clk_sys_i);
      rst_n_i = 1'h1;
      // Reads only touch places written or preloaded first
      for (int i = 0; i < 4; i++) begin
         m[i] = {12'h000, 8'($urandom)};
         go(1'h0, WR, 13'(i), m[i], 2'h0);
         q.push_back(m[i]);
         go(1'h1, RD, 13'(i), 20'h00000, 2'h0);
      end
      go(1'h0, NOCE, 13'h0000, ~m[0], 2'h0);
      q.push_back(m[0]);
      go(1'h0, RD, 13'h0000, 20'h00000, 2'h0);
      q.push_back(m[1]);
      go(1'h0, RD, 13'h0001, 20'h00000, 2'h0);
      q.push_back(m[1]);
      go(1'h0, RDH, 13'h0002, 20'h00000, 2'h0);
      q.push_back(20'h00000);
      go(1'h0, CLR, 13'h0002, 20'h00000, 2'h0);
      q.push_back(20'h00000);
      go(1'h1, CLR, 13'h0000, 20'h00000, 2'h0);
      fin(1);
      width_a_i = W10;
      width_b_i = W5;
      m[2] = {10'h000, 10'($urandom)};
      go(1'h0, WR, 13'h0004, m[2], 2'h0);
      q.push_back({15'h0000, m[2][4:0]});
      go(1'h1, RD, 13'h0008, 20'h00000, 2'h0);
      q.push_back({15'h0000, m[2][9:5]});
      go(1'h1, RD, 13'h0009, 20'h00000, 2'h0);
      fin(2);
      mode_i = MODE_SDP;
      width_a_i = W16;
      width_b_i = W16;
      m[3] = {4'h0, 16'($urandom)};
      go(1'h0, WR, 13'h0001, m[3], BE_ALL);
      go(1'h0, WR, 13'h0001, ~m[3], 2'h1);
      q.push_back({4'h0, m[3][15:8], ~m[3][7:0]});
      go(1'h1, RD, 13'h0001, 20'h00000, 2'h0);
      fin(3);
      mode_i = MODE_ROM;
      width_a_i = W10;
      preload_i = '{1'h1, 10'h003, 10'h2A5};
      @(negedge clk_sys_i);
      preload_i = '0;
      go(1'h0, WR, 13'h0003, 20'h00000, 2'h0);
      q.push_back(20'h002A5);
      go(1'h0, RD, 13'h0003, 20'h00000, 2'h0);
      fin(4);
      mode_i = MODE_SP;
      width_a_i = W8;
      go(1'h0, WR, 13'h0005, m[0], 2'h0);
      q.push_back(m[0]);
      go(1'h0, RD, 13'h0005, 20'h00000, 2'h0);
      fin(5);
      repeat (2) @(negedge clk_sys_i);
      end_of_test();
   end
endmodule
bind ebr_core ebr_monitor i_ebr_monitor (.clk_sys_i, .rst_n_i, .mode_i,
   .port_a_i, .port_b_i, .rdata_a_o, .rdata_b_o);
`default_nettype wire
